// ==== dv/qwi_host.sv ====
/* two-wire bus controller model: makes scl, pulls sda low.
   assumes an outside pull-up resolves sda from all pull-downs. */
`timescale 1ns/100ps
module qwi_host (
    // resolved data line
    input wire sda_in,
    // driven lines
    output reg scl_out,
    output reg sda_pull_out
);
    localparam real Q = 31.25; // quarter of the 125 ns link period
    // scl stands high between frames
    initial begin
        scl_out = 1'b1;
        sda_pull_out = 1'b0;
    end
    // one slot: data moves in scl low, sampled mid-high
    task xbit(input logic pull, output logic s);
        sda_pull_out = pull;
        #(Q) scl_out = 1'b1;
        #(Q) s = sda_in;
        #(Q) scl_out = 1'b0;
        #(Q);
    endtask
    // start, also usable as repeated start
    task start;
        sda_pull_out = 1'b0;
        #(Q) scl_out = 1'b1;
        #(Q) sda_pull_out = 1'b1;
        #(Q) scl_out = 1'b0;
        #(Q);
    endtask
    task stop;
        sda_pull_out = 1'b1;
        #(Q) scl_out = 1'b1;
        #(Q) sda_pull_out = 1'b0;
        #(Q);
    endtask
    // byte out msb first, then the target's answer
    task wbyte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            xbit(~b[i], s);
        xbit(1'b0, s);
        ack = ~s;
    endtask
    // byte in; last byte is refused so the target lets go
    task rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b0, s);
            d[i] = s;
        end
        xbit(~last, s);
    endtask
    // repeat address with write until the target answers
    task poll(input logic [6:0] a, output int tries);
        logic ack;
        tries = 0;
        ack = 1'b0;
        while (!ack && tries < 64) begin
            start();
            wbyte({a, 1'b0}, ack);
            stop();
            tries++;
        end
    endtask
endmodule // qwi_host

// ==== dv/qwi_top_assertions.sv ====
/* port checker for qwi_top: link drive, programming, guard, reset.
   assumes the link keeps scl low and high for at least 6 clocks. */
`timescale 1ns/100ps
module qwi_chk #(
    parameter PROG_CYCLES = 16
) (
    // clock and reset
    input wire clock_in,
    input wire reset_n_in,
    // serial link
    input wire scl_in,
    input wire sda_in,
    input wire sda_out,
    input wire sda_oe_out,
    // straps and guard
    input wire addr_select_pin_lo_in,
    input wire addr_select_pin_hi_in,
    input wire write_guard_n_in,
    // wipers and status
    input wire [7:0] wiper_ch0_out,
    input wire [7:0] wiper_ch1_out,
    input wire [7:0] wiper_ch2_out,
    input wire [7:0] wiper_ch3_out,
    input wire prog_busy_out
);
    reg [15:0] busy_cnt_r;
    reg [3:0] guard_cnt_r;
    reg [3:0] scl_cnt_r;
    wire [31:0] wipers;
    assign wipers = {wiper_ch3_out, wiper_ch2_out, wiper_ch1_out,
        wiper_ch0_out};
    // run lengths; the short ones saturate so idle never wraps
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            busy_cnt_r <= 16'h0000;
            guard_cnt_r <= 4'h0;
            scl_cnt_r <= 4'h0;
        end else begin
            busy_cnt_r <= prog_busy_out ? busy_cnt_r + 16'h0001 : 16'h0000;
            if (write_guard_n_in)
                guard_cnt_r <= 4'h0;
            else if (guard_cnt_r != 4'hf)
                guard_cnt_r <= guard_cnt_r + 4'h1;
            if (!scl_in)
                scl_cnt_r <= 4'h0;
            else if (scl_cnt_r != 4'hf)
                scl_cnt_r <= scl_cnt_r + 4'h1;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!reset_n_in);
    property p_sda_zero; sda_out == 1'b0; endproperty
    property p_oe_scl_high;
        scl_in && $past(scl_in) |-> $stable(sda_oe_out);
    endproperty
    property p_idle_release; scl_cnt_r == 4'hf |-> !sda_oe_out; endproperty
    property p_reset_vals;
        $rose(reset_n_in) |-> wipers == 32'h0000_0000 && !prog_busy_out
            && !sda_oe_out;
    endproperty
    property p_busy_wipers; prog_busy_out [*2] |-> $stable(wipers); endproperty
    property p_busy_len;
        $fell(prog_busy_out) |-> busy_cnt_r == PROG_CYCLES;
    endproperty
    property p_guard_hold; guard_cnt_r >= 4'h8 |-> $stable(wipers); endproperty
    property p_guard_nobusy;
        guard_cnt_r >= 4'h8 |-> !$rose(prog_busy_out);
    endproperty
    a_sda_zero: assert property (p_sda_zero)
        else $error("sda drive value not low");
    a_oe_scl_high: assert property (p_oe_scl_high)
        else $error("sda drive changed while scl high");
    a_idle_release: assert property (p_idle_release)
        else $error("sda pulled on idle bus");
    a_reset_vals: assert property (p_reset_vals)
        else $error("outputs not at reset values");
    a_busy_wipers: assert property (p_busy_wipers)
        else $error("wiper moved during programming");
    a_busy_len: assert property (p_busy_len)
        else $error("programming length wrong");
    a_guard_hold: assert property (p_guard_hold)
        else $error("wiper written while guarded");
    a_guard_nobusy: assert property (p_guard_nobusy)
        else $error("programming started while guarded");
    c_busy: cover property ($rose(prog_busy_out));
    c_ack: cover property ($rose(sda_oe_out));
    c_wiper: cover property (!$stable(wipers));
endmodule // qwi_chk

bind qwi_top qwi_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
    .clock_in(clock_in), .reset_n_in(reset_n_in), .scl_in(scl_in),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .addr_select_pin_lo_in(addr_select_pin_lo_in),
    .addr_select_pin_hi_in(addr_select_pin_hi_in),
    .write_guard_n_in(write_guard_n_in), .wiper_ch0_out(wiper_ch0_out),
    .wiper_ch1_out(wiper_ch1_out), .wiper_ch2_out(wiper_ch2_out),
    .wiper_ch3_out(wiper_ch3_out), .prog_busy_out(prog_busy_out));

// ==== dv/qwi_top_tb.sv ====
/* self-checking bench for qwi_top driven by the bus controller model.
   assumes qwi_host and the bound checker are compiled alongside. */
`timescale 1ns/100ps
module qwi_top_tb;
    localparam PROG = 512; // long enough that the first poll is refused
    localparam logic [6:0] ADR = {5'b01011, 1'b1, 1'b0};
    logic clock_in, reset_n_in, scl, sda_pull, sda_oe, sda_drv, sda;
    logic pin_lo, pin_hi, guard_n, busy;
    logic [7:0] w0, w1, w2, w3;
    logic [7:0] wd [8];
    logic [7:0] rd_q [8];
    int err_count, compares, cyc;
    // open-drain line with pull-up
    assign sda = (sda_pull | (sda_oe & ~sda_drv)) ? 1'b0 : 1'b1;
    qwi_top #(.WIPER_BITS(8), .PROG_CYCLES(PROG)) DUT (
        .clock_in(clock_in), .reset_n_in(reset_n_in), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_drv), .sda_oe_out(sda_oe),
        .addr_select_pin_lo_in(pin_lo), .addr_select_pin_hi_in(pin_hi),
        .write_guard_n_in(guard_n), .wiper_ch0_out(w0),
        .wiper_ch1_out(w1), .wiper_ch2_out(w2), .wiper_ch3_out(w3),
        .prog_busy_out(busy));
    qwi_host HOST (.sda_in(sda), .scl_out(scl), .sda_pull_out(sda_pull));
    task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk1(input string n, input logic e, input logic g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task finish_test;
        if (err_count == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // write frame: address, instruction, n bytes from wd
    task wr(input logic [7:0] ins, input int n);
        logic a;
        HOST.start();
        HOST.wbyte({ADR, 1'b0}, a);
        chk1("addr ack", 1'b1, a);
        HOST.wbyte(ins, a);
        chk1("instr ack", 1'b1, a);
        for (int i = 0; i < n; i++) begin
            HOST.wbyte(wd[i], a);
            chk1("data ack", 1'b1, a);
        end
        HOST.stop();
    endtask
    // read n bytes from the kept pointer
    task rd(input int n);
        logic a;
        HOST.start();
        HOST.wbyte({ADR, 1'b1}, a);
        chk1("read ack", 1'b1, a);
        for (int i = 0; i < n; i++)
            HOST.rbyte(i == n - 1, rd_q[i]);
        HOST.stop();
    endtask
    // pointer set by address-only write, then repeated start read
    task rr(input logic [7:0] ins, input int n);
        logic a;
        HOST.start();
        HOST.wbyte({ADR, 1'b0}, a);
        HOST.wbyte(ins, a);
        rd(n);
    endtask
    task nv_wait;
        int t;
        HOST.poll(ADR, t);
        chk1("refused while busy", 1'b1, t > 1);
    endtask
    task t_reset;
        logic a;
        chk8("wiper0 reset", 8'h00, w0);
        chk8("wiper1 reset", 8'h00, w1);
        chk8("wiper2 reset", 8'h00, w2);
        chk8("wiper3 reset", 8'h00, w3);
        chk1("busy reset", 1'b0, busy);
        HOST.start();
        HOST.wbyte({5'b01011, 2'b01, 1'b0}, a); // straps crossed
        HOST.stop();
        chk1("foreign addr ack", 1'b0, a);
    endtask
    // volatile run from 2 across reserved slots and the wrap
    task t_vol;
        wd = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66, 8'h77, 8'h00};
        wr(8'h02, 7);
        chk8("wiper0 wrap", 8'h77, w0);
        chk8("wiper1 kept", 8'h00, w1);
        chk8("wiper2", 8'h11, w2);
        chk8("wiper3", 8'h22, w3);
        rd(3);
        chk8("current read 0", 8'h00, rd_q[0]);
        chk8("current read 1", 8'h11, rd_q[1]);
        chk8("current read 2", 8'h22, rd_q[2]);
    endtask
    // nonvolatile run over the top, restore and store commands
    task t_nv;
        wd[0] = 8'h3c;
        wd[1] = 8'ha5;
        wr(8'h2f, 2);
        nv_wait();
        rr(8'h2f, 2);
        chk8("user byte 15", 8'h3c, rd_q[0]);
        chk8("stored wiper0", 8'ha5, rd_q[1]);
        wr(8'h88, 0);
        chk8("restored wiper0", 8'ha5, w0);
        wr(8'h93, 0);
        nv_wait();
        rr(8'h23, 1);
        chk8("stored wiper3", 8'h22, rd_q[0]);
    endtask
    // guarded write is dropped, reads still served
    task t_guard;
        @(posedge clock_in) guard_n <= 1'b0;
        wd[0] = 8'h5e;
        wr(8'h01, 1);
        chk8("guarded wiper1", 8'h00, w1);
        rr(8'h03, 1);
        chk8("guarded read", 8'h22, rd_q[0]);
        @(posedge clock_in) guard_n <= 1'b1;
    endtask
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end
    // hang ceiling, several times the expected run
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        reset_n_in = 1'b0;
        pin_lo = 1'b0;
        pin_hi = 1'b1;
        guard_n = 1'b1;
        repeat (8) @(posedge clock_in);
        reset_n_in <= 1'b1;
        repeat (8) @(posedge clock_in);
        t_reset();
        t_vol();
        t_nv();
        t_guard();
        finish_test();
    end
endmodule // qwi_top_tb

// ==== rtl/qwi_regs.vh ====
/*
 * constants for the quad wiper two-wire register access block:
 * instruction byte layout, address ranges, reset values, timing.
 * assumes inclusion by bare name from rtl/qwi_top.v only.
 */
`ifndef QWI_REGS_VH
`define QWI_REGS_VH

// target address: fixed prefix, then the two select pins
`define QWI_ADDR_PREFIX 5'h0b

// instruction byte fields
`define QWI_INSTR_CMD_BIT 7
`define QWI_INSTR_EE_BIT 5
`define QWI_REG_ADDR_MSB 4
`define QWI_QC_CODE_MSB 6
`define QWI_QC_CODE_LSB 3
`define QWI_QC_ADDR_MSB 2

// quick command codes
`define QWI_QC_RESTORE 4'h1
`define QWI_QC_STORE 4'h2

// address ranges
`define QWI_VOL_LAST 5'h07
`define QWI_WIPER_LAST 5'h03
`define QWI_NV_LAST 5'h0f

// reset values
`define QWI_WIPER_RST 8'h00
`define QWI_STORE_RST 8'h00

// buffered entry kinds
`define QWI_K_WIPER 2'h0
`define QWI_K_NV 2'h1
`define QWI_K_QC 2'h2

// nonvolatile programming time in clock cycles, and write buffer depth
`define QWI_PROG_CYCLES 1024
`define QWI_FIFO_DEPTH 4

`endif

// ==== rtl/qwi_top.v ====
/*
 * quad wiper two-wire target: register access over the serial link,
 * four wiper registers, sixteen nonvolatile bytes, a 4-entry write
 * buffer module (qwi_fifo) and the top (qwi_top).
 * assumes scl/sda arrive asynchronously from a bus controller and an
 * outside open-drain resolution of sda from sda_out/sda_oe_out.
 */
// Notes on behaviour
// [RULE_01] acknowledge drives data low in slot; not-acknowledge leaves it high
// [RULE_02] address byte direction bit one reads, zero writes
// [RULE_03] answer only when the two address bits match select pins
// [RULE_04] instruction command bit one means quick command, zero register
// [RULE_05] memory select one targets nonvolatile store, zero the wipers
// [RULE_06] five-bit address; wipers at 0..3, other volatile slots reserved
// [RULE_07] wiper holds 8 bits, or 6 bits with top two ignored
// [RULE_08] consecutive volatile writes advance over eight addresses then wrap
// [RULE_09] write starting at N fills N, N+1, wrapping to channel 0
// [RULE_10] single and consecutive writes work the same for nonvolatile store
// [RULE_11] store 0..3 hold saved wipers, 4..15 are user bytes
// [RULE_12] after a nonvolatile write the link is silent until programmed
// [RULE_13] host polls with address and write until acknowledged
// [RULE_14] read without new address starts at kept pointer, then increments
// [RULE_15] host sets pointer by an address-only write before reading
// [RULE_16] nonvolatile reads return saved wipers at 0..3, user bytes above
// [RULE_17] any legal code may be written to a saved wiper directly
// [RULE_18] quick command holds four code bits and three address bits
// [RULE_19] target address is fixed five-bit prefix plus two pin levels
// [RULE_20] write guard low blocks all writes; reads still work
// [RULE_21] code 0010 saves wiper to store, 0001 restores it
// [RULE_22] writes to reserved volatile slots are dropped, pointer still moves
// [RULE_23] on 6-bit variant the two upper wiper bits read as zero
`timescale 1ns/100ps
`include "qwi_regs.vh"

module qwi_fifo #(
    parameter WIDTH = 15,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire clock_in,
    input wire reset_n_in,
    // fill side
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    // drain side
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_r;
    reg [AW-1:0] rd_r;
    reg [AW:0] cnt_r;
    wire push;
    wire pop;

    assign in_ready_out = (cnt_r != DEPTH[AW:0]);
    assign out_valid_out = (cnt_r != {(AW+1){1'b0}});
    assign out_data_out = mem_r[rd_r];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // storage has no reset; only valid slots are ever read
    always @(posedge clock_in) begin
        if (push) begin
            mem_r[wr_r] <= in_data_in;
        end
    end

    // pointers wrap at depth, so depth need not be a power of two
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wr_r <= {AW{1'b0}};
            rd_r <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rd_r + 1'b1;
            end
            if (push & ~pop) begin
                cnt_r <= cnt_r + 1'b1;
            end else if (pop & ~push) begin
                cnt_r <= cnt_r - 1'b1;
            end
        end
    end
endmodule // qwi_fifo

module qwi_top #(
    parameter WIPER_BITS = 8,
    parameter PROG_CYCLES = `QWI_PROG_CYCLES
) (
    // clock and reset
    input wire clock_in,
    input wire reset_n_in,
    // serial link
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe_out,
    // straps and guard
    input wire addr_select_pin_lo_in,
    input wire addr_select_pin_hi_in,
    input wire write_guard_n_in,
    // wiper positions and status
    output reg [7:0] wiper_ch0_out,
    output reg [7:0] wiper_ch1_out,
    output reg [7:0] wiper_ch2_out,
    output reg [7:0] wiper_ch3_out,
    output reg prog_busy_out
);
    localparam [3:0] ST_IDLE = 4'h0;
    localparam [3:0] ST_ADDR = 4'h1;
    localparam [3:0] ST_AACK = 4'h2;
    localparam [3:0] ST_INSTR = 4'h3;
    localparam [3:0] ST_IACK = 4'h4;
    localparam [3:0] ST_WDATA = 4'h5;
    localparam [3:0] ST_DACK = 4'h6;
    localparam [3:0] ST_RDATA = 4'h7;
    localparam [3:0] ST_RACK = 4'h8;
    localparam [7:0] WMASK = (WIPER_BITS == 6) ? 8'h3f : 8'hff;
    localparam FW = 15;

    // next pointer: volatile walks eight slots, store walks sixteen
    function [4:0] ptr_next;
        input ee;
        input [4:0] p;
        begin
            if (!ee) begin
                ptr_next = (p >= `QWI_VOL_LAST) ? 5'h00 : p + 5'h01; // RULE_08
            end else begin
                ptr_next = {1'b0, p[3:0] + 4'h1};
            end
        end
    endfunction

    reg [4:0] sy1_r;
    reg [4:0] sy2_r;
    reg [4:0] sy3_r;
    reg [4:0] flt_r;
    reg scl_d_r;
    reg sda_d_r;
    reg [3:0] st_r;
    reg [2:0] cnt_r;
    reg done_r;
    reg [7:0] shift_r;
    reg [7:0] tx_r;
    reg [4:0] ptr_r;
    reg ee_r;
    reg ack_r;
    reg [7:0] wiper_r [0:3];
    reg [7:0] store_r [0:15];
    reg [15:0] busy_cnt_r;
    reg push_v;
    reg [FW-1:0] push_d;
    reg [7:0] rd_mux;
    wire [4:0] flt_nxt;
    wire scl;
    wire sda;
    wire scl_rise;
    wire scl_fall;
    wire start_c;
    wire stop_c;
    wire [7:0] byte_in;
    wire addr_hit;
    wire fifo_ready;
    wire fifo_valid;
    wire [FW-1:0] fifo_q;
    wire drain;
    wire [1:0] q_kind;
    wire [4:0] q_addr;
    wire [7:0] q_data;
    integer i;

    // a filtered bit changes only once stages two and three agree
    assign flt_nxt = (~(sy2_r ^ sy3_r) & sy3_r) | ((sy2_r ^ sy3_r) & flt_r);
    assign scl = flt_r[0];
    assign sda = flt_r[1];
    assign scl_rise = scl & ~scl_d_r;
    assign scl_fall = ~scl & scl_d_r;
    assign start_c = scl & scl_d_r & sda_d_r & ~sda;
    assign stop_c = scl & scl_d_r & ~sda_d_r & sda;
    assign byte_in = shift_r;
    assign addr_hit = (byte_in[7:3] == `QWI_ADDR_PREFIX) // RULE_19
        & (byte_in[2:1] == {flt_r[4], flt_r[3]}); // RULE_03

    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sy1_r <= 5'h1b;
            sy2_r <= 5'h1b;
            sy3_r <= 5'h1b;
            flt_r <= 5'h1b;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            sy1_r <= {addr_select_pin_hi_in, addr_select_pin_lo_in,
                write_guard_n_in, sda_in, scl_in};
            sy2_r <= sy1_r;
            sy3_r <= sy2_r;
            flt_r <= flt_nxt;
            scl_d_r <= scl;
            sda_d_r <= sda;
        end
    end

    // read data for the current pointer
    always @* begin
        rd_mux = 8'h00;
        if (ee_r) begin
            rd_mux = store_r[ptr_r[3:0]]; // RULE_16
        end else if (ptr_r <= `QWI_WIPER_LAST) begin
            rd_mux = wiper_r[ptr_r[1:0]] & WMASK; // RULE_23
        end
    end

    // bytes to buffer: quick commands and data bytes
    always @* begin
        push_v = 1'b0;
        push_d = {FW{1'b0}};
        if (scl_fall & done_r) begin
            if (st_r == ST_INSTR && byte_in[`QWI_INSTR_CMD_BIT]) begin
                push_v = 1'b1; // RULE_04
                push_d = {`QWI_K_QC, 2'b00,
                    byte_in[`QWI_QC_ADDR_MSB:0], // RULE_18
                    4'h0, byte_in[`QWI_QC_CODE_MSB:`QWI_QC_CODE_LSB]};
            end else if (st_r == ST_WDATA) begin
                push_v = 1'b1;
                push_d = {(ee_r ? `QWI_K_NV : `QWI_K_WIPER), ptr_r,
                    byte_in}; // RULE_05 RULE_10
            end
        end
    end

    // link side: one edge of the filtered clock per step
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= ST_IDLE;
            cnt_r <= 3'h0;
            done_r <= 1'b0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ptr_r <= 5'h00;
            ee_r <= 1'b0;
            ack_r <= 1'b0;
            sda_oe_out <= 1'b0;
            sda_out <= 1'b0;
        end else if (start_c) begin
            st_r <= ST_ADDR;
            cnt_r <= 3'h0;
            done_r <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (stop_c) begin
            st_r <= ST_IDLE;
            sda_oe_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            if (scl_rise) begin
                cnt_r <= cnt_r + 3'h1;
                done_r <= (cnt_r == 3'h7);
                shift_r <= {shift_r[6:0], sda};
                ack_r <= ~sda; // host ack sampled in the read ack slot
            end
            if (scl_fall) begin
                case (st_r)
                ST_ADDR: begin
                    if (done_r) begin
                        done_r <= 1'b0;
                        // silent while programming or buffer not empty
                        if (addr_hit & ~prog_busy_out & ~fifo_valid) begin
                            st_r <= ST_AACK; // RULE_12 RULE_13
                            sda_oe_out <= 1'b1; // RULE_01
                            ee_r <= ee_r;
                            tx_r <= byte_in[0] ? rd_mux : 8'h00; // RULE_02
                        end else begin
                            st_r <= ST_IDLE;
                        end
                    end
                end
                ST_AACK: begin
                    cnt_r <= 3'h0;
                    // ack slot shifted once more: direction bit is now bit 1
                    if (shift_r[1]) begin
                        st_r <= ST_RDATA; // RULE_14
                        sda_oe_out <= ~rd_mux[7];
                        tx_r <= {rd_mux[6:0], 1'b0};
                    end else begin
                        st_r <= ST_INSTR;
                        sda_oe_out <= 1'b0;
                    end
                end
                ST_INSTR: begin
                    if (done_r) begin
                        done_r <= 1'b0;
                        st_r <= ST_IACK;
                        if (!byte_in[`QWI_INSTR_CMD_BIT]) begin
                            ee_r <= byte_in[`QWI_INSTR_EE_BIT]; // RULE_05
                            ptr_r <= byte_in[`QWI_REG_ADDR_MSB:0]; // RULE_06
                            sda_oe_out <= 1'b1; // RULE_15
                        end else begin
                            sda_oe_out <= fifo_ready;
                        end
                    end
                end
                ST_WDATA: begin
                    if (done_r) begin
                        done_r <= 1'b0;
                        st_r <= ST_DACK;
                        sda_oe_out <= fifo_ready; // full buffer: not ack
                        if (fifo_ready) begin
                            ptr_r <= ptr_next(ee_r, ptr_r); // RULE_09 RULE_22
                        end
                    end
                end
                ST_IACK, ST_DACK: begin
                    cnt_r <= 3'h0;
                    st_r <= sda_oe_out ? ST_WDATA : ST_IDLE;
                    sda_oe_out <= 1'b0;
                end
                ST_RDATA: begin
                    if (done_r) begin
                        done_r <= 1'b0;
                        st_r <= ST_RACK;
                        sda_oe_out <= 1'b0;
                        ptr_r <= ptr_next(ee_r, ptr_r); // RULE_14
                    end else begin
                        sda_oe_out <= ~tx_r[7];
                        tx_r <= {tx_r[6:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    cnt_r <= 3'h0;
                    if (ack_r) begin
                        st_r <= ST_RDATA;
                        sda_oe_out <= ~rd_mux[7];
                        tx_r <= {rd_mux[6:0], 1'b0};
                    end else begin
                        st_r <= ST_IDLE; // host ended the read
                    end
                end
                default: begin
                    st_r <= ST_IDLE;
                    sda_oe_out <= 1'b0;
                end
                endcase
            end
        end
    end

    // write buffer between the link and the register file
    qwi_fifo #(
        .WIDTH(FW),
        .DEPTH(`QWI_FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .clock_in(clock_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(push_v),
        .in_ready_out(fifo_ready),
        .in_data_in(push_d),
        .out_valid_out(fifo_valid),
        .out_ready_in(~prog_busy_out),
        .out_data_out(fifo_q)
    );

    assign drain = fifo_valid & ~prog_busy_out;
    assign q_kind = fifo_q[14:13];
    assign q_addr = fifo_q[12:8];
    assign q_data = fifo_q[7:0];

    // register side: drain stalls for each programming cycle
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (i = 0; i < 4; i = i + 1) begin
                wiper_r[i] <= `QWI_WIPER_RST;
            end
            for (i = 0; i < 16; i = i + 1) begin
                store_r[i] <= `QWI_STORE_RST;
            end
            busy_cnt_r <= 16'h0000;
            prog_busy_out <= 1'b0;
        end else begin
            if (busy_cnt_r != 16'h0000) begin
                busy_cnt_r <= busy_cnt_r - 16'h0001;
            end
            prog_busy_out <= (busy_cnt_r > 16'h0001);
            // guard low: every buffered write or command is dropped
            if (drain & flt_r[2]) begin // RULE_20
                case (q_kind)
                `QWI_K_WIPER: begin
                    if (q_addr <= `QWI_WIPER_LAST) begin // RULE_22
                        wiper_r[q_addr[1:0]] <= q_data & WMASK; // RULE_07
                    end
                end
                `QWI_K_NV: begin
                    store_r[q_addr[3:0]] <= q_data; // RULE_11 RULE_17
                    busy_cnt_r <= PROG_CYCLES[15:0]; // RULE_12
                    prog_busy_out <= 1'b1;
                end
                `QWI_K_QC: begin
                    if (!q_addr[2] && q_data[3:0] == `QWI_QC_RESTORE) begin
                        wiper_r[q_addr[1:0]] <=
                            store_r[q_addr[1:0]] & WMASK; // RULE_21
                    end
                    if (!q_addr[2] && q_data[3:0] == `QWI_QC_STORE) begin
                        store_r[q_addr[1:0]] <= wiper_r[q_addr[1:0]];
                        busy_cnt_r <= PROG_CYCLES[15:0]; // RULE_21
                        prog_busy_out <= 1'b1;
                    end
                end
                default: begin
                    busy_cnt_r <= busy_cnt_r;
                end
                endcase
            end
        end
    end

    // wiper outputs mirror the registers one cycle later
    always @(posedge clock_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wiper_ch0_out <= `QWI_WIPER_RST;
            wiper_ch1_out <= `QWI_WIPER_RST;
            wiper_ch2_out <= `QWI_WIPER_RST;
            wiper_ch3_out <= `QWI_WIPER_RST;
        end else begin
            wiper_ch0_out <= wiper_r[0];
            wiper_ch1_out <= wiper_r[1];
            wiper_ch2_out <= wiper_r[2];
            wiper_ch3_out <= wiper_r[3];
        end
    end
endmodule // qwi_top
